// [flash_ctl_pkg.sv]
// constants, codes and types shared by the serial flash command decoder
// assumes a 25 MHz system clock and a serial clock made by the host
package flash_ctl_pkg;

  // opcodes
  localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_FACTORY_MODE      = 8'h41;
  localparam logic [7:0] OP_STD_IDENT         = 8'h9f;
  localparam logic [7:0] OP_QUAD_IDENT        = 8'haf;
  localparam logic [7:0] OP_LEGACY_SIGNATURE  = 8'hab;
  localparam logic [7:0] OP_MAKER_DEVICE      = 8'h90;
  localparam logic [7:0] OP_RESET_ARM         = 8'h66;
  localparam logic [7:0] OP_RESET             = 8'h99;

  // identity values, arbitrary
  localparam logic [7:0] ID_MAKER     = 8'h5a;
  localparam logic [7:0] ID_MEM_TYPE  = 8'h3c;
  localparam logic [7:0] ID_DENSITY   = 8'h17;
  localparam logic [7:0] ID_DEVICE    = 8'h42;
  localparam logic [7:0] ID_SIGNATURE = 8'h42;

  // link framing
  localparam logic [2:0] SPI_LAST_CLOCK  = 3'h7;
  localparam logic [2:0] QUAD_LAST_CLOCK = 3'h1;
  localparam logic [1:0] SIG_DUMMY_BYTES = 2'h2;
  localparam logic [1:0] MD_ARG_BYTES    = 2'h3;
  localparam logic [1:0] ONE_BYTE_LEFT   = 2'h1;
  localparam logic [1:0] JEDEC_LAST_IDX  = 2'h2;
  localparam logic [1:0] MD_LAST_IDX     = 2'h1;
  localparam logic [1:0] SIG_LAST_IDX    = 2'h0;
  localparam logic [3:0] SPI_OUT_ENABLE  = 4'h2;
  localparam logic [3:0] QUAD_OUT_ENABLE = 4'hf;

  // release delay from deep power-down
  localparam int RELEASE_DELAY_NS     = 10000;
  localparam int CLOCK_PERIOD_NS      = 40;
  localparam int RELEASE_DELAY_CYCLES = (RELEASE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DELAY_W              = 9;
  localparam logic [DELAY_W-1:0] RELEASE_DELAY_COUNT = DELAY_W'(RELEASE_DELAY_CYCLES);

  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_ARGS   = 2'b01,
    PH_SEND   = 2'b10,
    PH_IDLE   = 2'b11
  } link_phase_e;

  typedef enum logic [1:0] {
    ID_JEDEC      = 2'b00,
    ID_MAKER_DEV  = 2'b01,
    ID_SIG        = 2'b10
  } id_kind_e;

endpackage

// [link_capture.sv]
// serial clock side holding register: level synchronisers and the accepted opcode word
// assumes i_load is a one-edge strobe from logic on the same serial clock
`timescale 1ns/1ps
module link_capture import flash_ctl_pkg::*; (
  input  wire logic       i_sclk,
  input  wire logic       i_sys_rst,
  input  wire logic [2:0] i_levels,
  input  wire logic       i_load,
  input  wire logic [7:0] i_opcode,
  output logic      [2:0] o_levels,
  output logic      [7:0] o_opcode,
  output logic            o_toggle
);

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] lvl;
    logic [7:0] opcode;
    logic       toggle;
  } cap_s;

  cap_s cap;
  cap_s next_cap;

  // levels come from the system clock; word and toggle cross back the other way
  always_comb begin
    next_cap      = cap;
    next_cap.meta = i_levels;
    next_cap.lvl  = cap.meta;
    if (i_load) begin
      next_cap.opcode = i_opcode;
      next_cap.toggle = ~cap.toggle;
    end
  end

  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cap <= '0;
    end else begin
      cap <= next_cap;
    end
  end

  assign o_levels = cap.lvl;
  assign o_opcode = cap.opcode;
  assign o_toggle = cap.toggle;

endmodule

// [flash_cmd_decoder.sv]
// serial flash command decoder: write latch, factory mode, soft reset, power-down release
// and identification output; assumes the host serial controller drives i_cs_n and i_sclk
// and that program/erase engines report busy and completion on the system clock
`timescale 1ns/1ps

// Operation
// - soft reset only when reset-arm 66 is directly followed by reset 99
// - legacy maker/device id takes 90h, two dummy bytes, one address byte
// - address 00h starts with maker code, 01h starts with device code
// - maker/device codes alternate msb first on falling edges until select rises
// - set-write-latch command sets the latch; host reissues before each write
// - latch, factory and release opcodes accepted as 8 single or 2 quad clocks
// - clear-write-latch command framed by select clears the latch
// - latch clears on reset pin, soft reset and completion of writing commands
// - suspend requests are refused while factory mode is active
// - factory flag clears on reset pin, program/erase completion and soft reset
// - standard id sends maker byte then two device bytes; select ends it
// - standard id is not decoded while busy; device returns to standby
// - release completes at select rise; delayed standby only from power-down
// - reset pin low takes the device out of deep power-down
// - release and signature accepted in power-down unless a write cycle runs
// - signature byte repeats while clocks continue; select rise ends it
// - program, erase and status-write are ignored while the latch is clear
// - quad id sends maker, type and density continuously on falling edges
module flash_cmd_decoder import flash_ctl_pkg::*; (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_io_in,
  output logic      [3:0] o_io_out,
  output logic      [3:0] o_io_oe,
  input  wire logic       i_reset_pin_n,
  input  wire logic       i_quad_command_mode,
  input  wire logic       i_busy,
  input  wire logic       i_powerdown_enter,
  input  wire logic       i_pe_cmd_req,
  output logic            o_pe_cmd_accept,
  input  wire logic       i_suspend_req,
  output logic            o_suspend_accept,
  input  wire logic       i_pe_done,
  input  wire logic       i_latch_clear_done,
  output logic            o_write_latch_flag,
  output logic            o_factory_mode,
  output logic            o_deep_powerdown,
  output logic            o_standby,
  output logic            o_soft_reset,
  output logic            o_cmd_valid,
  output logic      [7:0] o_cmd_opcode
);

  function automatic logic [7:0] id_byte(input id_kind_e kind, input logic [1:0] idx);
    logic [7:0] b;
    b = ID_SIGNATURE;
    if (kind == ID_JEDEC) begin
      b = (idx == 2'h0) ? ID_MAKER : ((idx == 2'h1) ? ID_MEM_TYPE : ID_DENSITY);
    end else if (kind == ID_MAKER_DEV) begin
      b = (idx == 2'h0) ? ID_MAKER : ID_DEVICE;
    end
    return b;
  endfunction

  function automatic logic [1:0] id_last(input id_kind_e kind);
    logic [1:0] l;
    l = SIG_LAST_IDX;
    if (kind == ID_JEDEC) begin
      l = JEDEC_LAST_IDX;
    end else if (kind == ID_MAKER_DEV) begin
      l = MD_LAST_IDX;
    end
    return l;
  endfunction

  // ---------------- serial clock domain ----------------
  typedef struct packed {
    link_phase_e phase;
    id_kind_e    kind;
    logic [2:0]  cnt;
    logic [1:0]  args_left;
    logic [1:0]  idx;
    logic [7:0]  shreg;
    logic [7:0]  obyte;
  } link_s;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pins_s;

  link_s lk;
  link_s next_lk;
  pins_s pins;
  pins_s next_pins;

  logic [2:0] link_levels;
  logic [7:0] link_opcode;
  logic       link_toggle;
  logic       accept;
  logic [7:0] sh_next;
  logic       last;
  logic       lvl_busy;
  logic       lvl_pd;
  logic       lvl_quad;
  logic       is_id;
  logic [1:0] nidx;
  logic [2:0] sys_levels;

  assign lvl_busy = link_levels[0];
  assign lvl_pd   = link_levels[1];
  assign lvl_quad = link_levels[2];

  always_comb begin
    next_lk = lk;
    accept  = 1'b0;
    is_id   = 1'b0;
    nidx    = 2'h0;
    sh_next = lvl_quad ? {lk.shreg[3:0], i_io_in} : {lk.shreg[6:0], i_io_in[0]};
    last    = lvl_quad ? (lk.cnt == QUAD_LAST_CLOCK) : (lk.cnt == SPI_LAST_CLOCK);
    next_lk.cnt = last ? 3'h0 : lk.cnt + 3'h1;
    unique case (lk.phase)
      PH_OPCODE: begin
        next_lk.shreg = sh_next;
        if (last) begin
          next_lk.phase = PH_IDLE;
          is_id = (sh_next == OP_LEGACY_SIGNATURE)
                | (!lvl_quad && (sh_next == OP_STD_IDENT || sh_next == OP_MAKER_DEVICE))
                | (lvl_quad && sh_next == OP_QUAD_IDENT);
          // power-down passes only the release/signature opcode; busy blocks id reads
          accept = (!lvl_pd || sh_next == OP_LEGACY_SIGNATURE) && !(lvl_busy && is_id);
          if (accept && is_id) begin
            next_lk.idx = 2'h0;
            if (sh_next == OP_LEGACY_SIGNATURE) begin
              next_lk.kind      = ID_SIG;
              next_lk.phase     = PH_ARGS;
              next_lk.args_left = SIG_DUMMY_BYTES;
            end else if (sh_next == OP_MAKER_DEVICE) begin
              next_lk.kind      = ID_MAKER_DEV;
              next_lk.phase     = PH_ARGS;
              next_lk.args_left = MD_ARG_BYTES;
            end else begin
              next_lk.kind  = ID_JEDEC;
              next_lk.phase = PH_SEND;
              next_lk.obyte = id_byte(ID_JEDEC, 2'h0);
            end
          end
        end
      end
      PH_ARGS: begin
        next_lk.shreg = sh_next;
        if (last) begin
          next_lk.args_left = lk.args_left - 2'h1;
          if (lk.args_left == ONE_BYTE_LEFT) begin
            next_lk.phase = PH_SEND;
            nidx = (lk.kind == ID_MAKER_DEV) ? {1'b0, sh_next[0]} : 2'h0;
            next_lk.idx   = nidx;
            next_lk.obyte = id_byte(lk.kind, nidx);
          end
        end
      end
      PH_SEND: begin
        next_lk.obyte = lvl_quad ? {lk.obyte[3:0], 4'h0} : {lk.obyte[6:0], 1'b0};
        if (last) begin
          // wraps forever; only the select rise ends the output
          nidx = (lk.idx == id_last(lk.kind)) ? 2'h0 : lk.idx + 2'h1;
          next_lk.idx   = nidx;
          next_lk.obyte = id_byte(lk.kind, nidx);
        end
      end
      PH_IDLE: begin
        next_lk.cnt = lk.cnt;
      end
    endcase
  end

  // select high clears the frame, so a partial opcode never reaches the system side
  always_ff @(posedge i_sclk or posedge i_cs_n or posedge i_sys_rst) begin
    if (i_sys_rst || i_cs_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  link_capture u_capture (
    .i_sclk    (i_sclk),
    .i_sys_rst (i_sys_rst),
    .i_levels  (sys_levels),
    .i_load    (accept),
    .i_opcode  (sh_next),
    .o_levels  (link_levels),
    .o_opcode  (link_opcode),
    .o_toggle  (link_toggle)
  );

  always_comb begin
    next_pins = '0;
    if (lk.phase == PH_SEND) begin
      next_pins.out = lvl_quad ? lk.obyte[7:4] : {2'b00, lk.obyte[7], 1'b0};
      next_pins.oe  = lvl_quad ? QUAD_OUT_ENABLE : SPI_OUT_ENABLE;
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n or posedge i_sys_rst) begin
    if (i_sys_rst || i_cs_n) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  assign o_io_out = pins.out;
  assign o_io_oe  = pins.oe;

  // ---------------- system clock domain ----------------
  typedef struct packed {
    logic [1:0]         cs_sync;
    logic               cs_prev;
    logic [1:0]         tog_sync;
    logic               tog_seen;
    logic [1:0]         rst_sync;
    logic [7:0]         cmd;
    logic               pending;
    logic               armed;
    logic               latch;
    logic               factory;
    logic               powerdown;
    logic               releasing;
    logic [DELAY_W-1:0] delay;
    logic               soft_reset;
    logic               cmd_valid;
    logic [2:0]         levels;
  } sys_s;

  sys_s sy;
  sys_s next_sy;
  logic       cs_rise;
  logic       pin_reset;
  logic       do_cmd;

  assign sys_levels = sy.levels;

  always_comb begin
    next_sy          = sy;
    next_sy.cs_sync  = {sy.cs_sync[0], i_cs_n};
    next_sy.cs_prev  = sy.cs_sync[1];
    next_sy.tog_sync = {sy.tog_sync[0], link_toggle};
    next_sy.rst_sync = {sy.rst_sync[0], i_reset_pin_n};
    next_sy.soft_reset = 1'b0;
    next_sy.cmd_valid  = 1'b0;
    cs_rise   = sy.cs_sync[1] && !sy.cs_prev;
    pin_reset = !sy.rst_sync[1];
    do_cmd    = sy.pending && sy.cs_sync[1];
    // opcode word is stable: the link changes it only in a later frame
    if (sy.tog_sync[1] != sy.tog_seen) begin
      next_sy.tog_seen = sy.tog_sync[1];
      next_sy.cmd      = link_opcode;
      next_sy.pending  = 1'b1;
    end
    if (i_latch_clear_done || i_pe_done) begin
      next_sy.latch = 1'b0;
    end
    if (i_pe_done) begin
      next_sy.factory = 1'b0;
    end
    if (sy.releasing) begin
      next_sy.delay = sy.delay - DELAY_W'(1);
      if (sy.delay == '0) begin
        next_sy.releasing = 1'b0;
      end
    end
    if (do_cmd) begin
      next_sy.pending   = 1'b0;
      next_sy.cmd_valid = 1'b1;
      next_sy.armed     = (sy.cmd == OP_RESET_ARM);
      unique case (sy.cmd)
        OP_SET_WRITE_LATCH:   next_sy.latch = 1'b1;
        OP_CLEAR_WRITE_LATCH: next_sy.latch = 1'b0;
        OP_FACTORY_MODE:      next_sy.factory = 1'b1;
        OP_LEGACY_SIGNATURE: begin
          if (sy.powerdown) begin
            next_sy.powerdown = 1'b0;
            next_sy.releasing = 1'b1;
            next_sy.delay     = RELEASE_DELAY_COUNT;
          end
        end
        OP_RESET: begin
          if (sy.armed) begin
            next_sy.soft_reset = 1'b1;
            next_sy.latch      = 1'b0;
            next_sy.factory    = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // entry beats a release that lands in the same cycle
    if (i_powerdown_enter) begin
      next_sy.powerdown = 1'b1;
    end
    if (pin_reset) begin
      next_sy.latch     = 1'b0;
      next_sy.factory   = 1'b0;
      next_sy.powerdown = 1'b0;
      next_sy.releasing = 1'b0;
      next_sy.armed     = 1'b0;
    end
    next_sy.levels = {i_quad_command_mode, sy.powerdown | sy.releasing, i_busy};
    if (cs_rise && !sy.pending && !do_cmd) begin
      next_sy.pending = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sy <= '0;
    end else begin
      sy <= next_sy;
    end
  end

  assign o_pe_cmd_accept    = i_pe_cmd_req && sy.latch;
  assign o_suspend_accept   = i_suspend_req && !sy.factory;
  assign o_write_latch_flag = sy.latch;
  assign o_factory_mode     = sy.factory;
  assign o_deep_powerdown   = sy.powerdown;
  assign o_standby          = !sy.powerdown && !sy.releasing && sy.cs_prev;
  assign o_soft_reset       = sy.soft_reset;
  assign o_cmd_valid        = sy.cmd_valid;
  assign o_cmd_opcode       = sy.cmd;

endmodule

// [flash_cmd_checker_assertions.sv]
// port assertions for the serial flash command decoder
// assumes one system clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module flash_cmd_checker import flash_ctl_pkg::*; (
  input wire logic       i_clock,
  input wire logic       i_sys_rst,
  input wire logic       i_cs_n,
  input wire logic [3:0] o_io_oe,
  input wire logic       i_reset_pin_n,
  input wire logic       i_pe_cmd_req,
  input wire logic       o_pe_cmd_accept,
  input wire logic       i_suspend_req,
  input wire logic       o_suspend_accept,
  input wire logic       i_pe_done,
  input wire logic       o_write_latch_flag,
  input wire logic       o_factory_mode,
  input wire logic       o_deep_powerdown,
  input wire logic       o_standby,
  input wire logic       o_soft_reset
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  property p_accept; o_pe_cmd_accept == (i_pe_cmd_req && o_write_latch_flag); endproperty
  a_accept: assert property (p_accept) else $error("write accept wrong");
  property p_suspend; o_suspend_accept == (i_suspend_req && !o_factory_mode); endproperty
  a_suspend: assert property (p_suspend) else $error("suspend accept wrong");
  property p_soft;
    o_soft_reset |-> ##1 !(o_write_latch_flag || o_factory_mode);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left flags");
  property p_done; i_pe_done |=> !(o_write_latch_flag || o_factory_mode); endproperty
  a_done: assert property (p_done) else $error("done left flags");
  property p_pin;
    !i_reset_pin_n [*3] |=> !(o_write_latch_flag || o_factory_mode || o_deep_powerdown);
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin left flags");
  property p_oe; i_cs_n |-> o_io_oe == 4'h0; endproperty
  a_oe: assert property (p_oe) else $error("driving while deselected");
  property p_pd; o_deep_powerdown |-> !o_standby; endproperty
  a_pd: assert property (p_pd) else $error("standby in power-down");
  property p_release; $fell(o_deep_powerdown) && i_reset_pin_n |-> !o_standby [*8]; endproperty
  a_release: assert property (p_release) else $error("release not delayed");
  property p_dead; o_deep_powerdown && !i_cs_n |=> o_deep_powerdown || i_cs_n; endproperty
  a_dead: assert property (p_dead) else $error("power-down left mid-frame");
  c_soft: cover property (o_soft_reset);
  c_release: cover property ($fell(o_deep_powerdown));
  c_accept: cover property (o_pe_cmd_accept);
endmodule

bind flash_cmd_decoder flash_cmd_checker u_chk (.*);

// [flash_host_model.sv]
// host serial controller model: frames opcodes and arguments, then clocks out reads
// assumes frame() is called from one process at a time, just after a system clock edge
`timescale 1ns/1ps
module flash_host_model import flash_ctl_pkg::*; (
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic      [3:0] o_io,
  input  wire logic [3:0] i_io_out,
  input  wire logic [3:0] i_io_oe
);
  logic [3:0] oe_seen;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
    oe_seen = 4'h0;
  end
  // only defined opcodes are framed; the serial clock stands low between frames
  task automatic frame(input logic quad, input logic [31:0] tx, input int n_tx,
                       input int n_rx, output logic [31:0] rx);
    logic [7:0] op;
    op = tx[31:24];
    rx = '0;
    oe_seen = 4'h0;
    #3 o_cs_n = 1'b0;
    for (int i = 0; i < n_tx + n_rx; i++) begin
      // upper lines toggle in single-bit mode so a decoder that reads them is caught
      o_io = quad ? tx[31:28] : {i[2:0], tx[31]};
      tx = quad ? tx << 4 : tx << 1;
      #80 o_sclk = 1'b1;
      if (i >= n_tx) begin
        rx = quad ? {rx[27:0], i_io_out} : {rx[30:0], i_io_out[1]};
        oe_seen = oe_seen | i_io_oe;
      end
      #80 o_sclk = 1'b0;
    end
    #40 o_cs_n = 1'b1;
    o_io = ~o_io;
    #400;
    if (op == OP_LEGACY_SIGNATURE) #(RELEASE_DELAY_NS);
  endtask
endmodule

// [tb.sv]
// self-checking bench for the serial flash command decoder
// assumes the host model frames one command at a time on a stopped serial clock
`timescale 1ns/1ps
module tb import flash_ctl_pkg::*;;
  logic        i_clock = 1'b0;
  logic        i_sys_rst = 1'b0;
  logic        i_cs_n, i_sclk;
  logic [3:0]  i_io_in, o_io_out, o_io_oe;
  logic        i_reset_pin_n = 1'b1;
  logic        i_quad_command_mode = 1'b0;
  logic        i_busy = 1'b0;
  logic        i_powerdown_enter = 1'b0;
  logic        i_pe_cmd_req = 1'b0;
  logic        i_suspend_req = 1'b0;
  logic        i_pe_done = 1'b0;
  logic        i_latch_clear_done = 1'b0;
  logic        o_pe_cmd_accept, o_suspend_accept, o_write_latch_flag, o_factory_mode;
  logic        o_deep_powerdown, o_standby, o_soft_reset, o_cmd_valid;
  logic [7:0]  o_cmd_opcode;
  logic [31:0] rx;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          srst_cnt = 0;
  int          cv_cnt = 0;
  int          cv_mark = 0;

  always #20 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_soft_reset === 1'b1) srst_cnt <= srst_cnt + 1;
  always @(posedge i_clock) if (o_cmd_valid === 1'b1) cv_cnt <= cv_cnt + 1;

  flash_host_model u_host (
    .o_cs_n   (i_cs_n),
    .o_sclk   (i_sclk),
    .o_io     (i_io_in),
    .i_io_out (o_io_out),
    .i_io_oe  (o_io_oe)
  );
  flash_cmd_decoder u_dut (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic cmd(input logic [7:0] op);
    u_host.frame(i_quad_command_mode, {op, 24'h0}, i_quad_command_mode ? 2 : 8, 0, rx);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge i_clock) {i_powerdown_enter, i_latch_clear_done, i_pe_done} <= m;
    @(posedge i_clock) {i_powerdown_enter, i_latch_clear_done, i_pe_done} <= 3'h0;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  // the mode level crosses late, so a short frame in the old framing carries it over;
  // it carries a defined opcode, since leaving quad completes a byte on its second clock
  task automatic mode(input logic m);
    @(posedge i_clock) i_quad_command_mode <= m;
    @(posedge i_clock);
    u_host.frame(!m, {OP_LEGACY_SIGNATURE, 24'h0}, 3, 0, rx);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    // a real edge, since the serial-clock side only resets on one
    i_sys_rst <= 1'b1;
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (6) @(negedge i_clock);
    chk({o_write_latch_flag, o_factory_mode, o_deep_powerdown, o_standby}, 4'h1);
    done("reset");
    cmd(OP_SET_WRITE_LATCH);
    @(posedge i_clock) i_pe_cmd_req <= 1'b1;
    @(negedge i_clock) chk({o_write_latch_flag, o_pe_cmd_accept}, 2'h3);
    u_host.frame(1'b0, {OP_CLEAR_WRITE_LATCH, 24'h0}, 7, 0, rx);
    chk(o_write_latch_flag, 1'b1);
    cmd(OP_CLEAR_WRITE_LATCH);
    chk({o_write_latch_flag, o_pe_cmd_accept}, 2'h0);
    chk(o_cmd_opcode, OP_CLEAR_WRITE_LATCH);
    cmd(OP_SET_WRITE_LATCH);
    pulse(3'h2);
    chk(o_write_latch_flag, 1'b0);
    done("latch");
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_FACTORY_MODE);
    @(posedge i_clock) i_suspend_req <= 1'b1;
    @(negedge i_clock) chk({o_factory_mode, o_suspend_accept}, 2'h2);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET);
    chk({o_write_latch_flag, o_factory_mode, o_suspend_accept}, 3'h1);
    chk(srst_cnt, 1);
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_RESET_ARM);
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_RESET);
    chk({o_write_latch_flag, srst_cnt[1:0]}, 3'h5);
    done("soft reset");
    u_host.frame(1'b0, {OP_STD_IDENT, 24'h0}, 8, 32, rx);
    chk(rx, {ID_MAKER, ID_MEM_TYPE, ID_DENSITY, ID_MAKER});
    chk(u_host.oe_seen, SPI_OUT_ENABLE);
    for (int a = 0; a < 2; a++) begin
      u_host.frame(1'b0, {OP_MAKER_DEVICE, 24'(a)}, 32, 32, rx);
      chk(rx, a ? {2{ID_DEVICE, ID_MAKER}} : {2{ID_MAKER, ID_DEVICE}});
    end
    done("ident");
    mode(1'b1);
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_FACTORY_MODE);
    chk({o_write_latch_flag, o_factory_mode}, 2'h3);
    pulse(3'h1);
    chk({o_write_latch_flag, o_factory_mode}, 2'h0);
    u_host.frame(1'b1, {OP_QUAD_IDENT, 24'h0}, 2, 8, rx);
    chk(rx, {ID_MAKER, ID_MEM_TYPE, ID_DENSITY, ID_MAKER});
    chk(u_host.oe_seen, QUAD_OUT_ENABLE);
    mode(1'b0);
    done("quad");
    cv_mark = cv_cnt;
    @(posedge i_clock) i_busy <= 1'b1;
    u_host.frame(1'b0, {OP_STD_IDENT, 24'h0}, 8, 16, rx);
    chk(u_host.oe_seen, 4'h0);
    pulse(3'h4);
    cmd(OP_LEGACY_SIGNATURE);
    chk({o_deep_powerdown, o_standby}, 2'h2);
    @(posedge i_clock) i_busy <= 1'b0;
    cmd(OP_SET_WRITE_LATCH);
    chk(o_write_latch_flag, 1'b0);
    chk(cv_cnt, cv_mark);
    u_host.frame(1'b0, {OP_LEGACY_SIGNATURE, 24'h0}, 24, 16, rx);
    chk(rx[15:0], {2{ID_SIGNATURE}});
    chk({o_cmd_opcode, 8'(cv_cnt - cv_mark)}, {OP_LEGACY_SIGNATURE, 8'h01});
    cmd(OP_LEGACY_SIGNATURE);
    chk({o_deep_powerdown, o_standby}, 2'h1);
    done("power-down");
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_FACTORY_MODE);
    pulse(3'h4);
    @(posedge i_clock) i_reset_pin_n <= 1'b0;
    repeat (5) @(posedge i_clock);
    i_reset_pin_n <= 1'b1;
    @(negedge i_clock) chk({o_write_latch_flag, o_factory_mode, o_deep_powerdown}, 3'h0);
    done("reset pin");
    report_and_stop();
  end
endmodule
